// [rivu_defs.vh]
// Purpose: Constants for the reset and interrupt vector unit
// Assumes: 100 MHz core clock, registers on a 6-bit I/O address space
// Notes: Times are kept in their own unit; tick counts derive from them
`ifndef RIVU_DEFS_VH
`define RIVU_DEFS_VH

// Register offsets in I/O space
`define RIVU_ADDR_STATUS 6'h3F
`define RIVU_ADDR_EXT_MASK 6'h3B
`define RIVU_ADDR_EXT_FLAG 6'h3A
`define RIVU_ADDR_CTRL 6'h35

// Field positions
`define RIVU_BIT_GIE 7
`define RIVU_BIT_EN_B 7
`define RIVU_BIT_EN_A 6
`define RIVU_BIT_FLAG_B 7
`define RIVU_BIT_FLAG_A 6
`define RIVU_CTRL_SENSE_B_HI 3
`define RIVU_CTRL_SENSE_B_LO 2
`define RIVU_CTRL_SENSE_A_HI 1
`define RIVU_CTRL_SENSE_A_LO 0

// Reset values
`define RIVU_RST_REG 8'h00
`define RIVU_RST_CTRL 4'h0

// Sense encodings for external requests
`define RIVU_SENSE_LEVEL 2'h0
`define RIVU_SENSE_FALL 2'h2
`define RIVU_SENSE_RISE 2'h3

// Vector addresses
`define RIVU_VEC_RESET 4'h0
`define RIVU_VEC_EXT_A 4'h1
`define RIVU_VEC_EXT_B 4'h2
`define RIVU_VEC_PERIPH0 4'h3
`define RIVU_NUM_IRQ 12
`define RIVU_NUM_PERIPH 10

// Timing
`define RIVU_CLK_MHZ 100
`define RIVU_POR_US 3000
`define RIVU_TOUT_SLOW_US 16000
`define RIVU_TOUT_FAST_US 1100
`define RIVU_PIN_LOW_MIN 2

`endif

// [rivu_top.v]
// Purpose: Reset sequencing and interrupt vectoring for an 8-bit core
// Assumes: rst is the power-on event; watchdog timeout arrives on core_clk
// Notes: Start-up delays count 1 us ticks from a divider of core_clk
//
// Overview of operation
// - Twelve interrupt sources plus reset, own vectors
// - Service only if own and global enable set
// - Lowest vector address wins; reset highest
// - Pin and watchdog reset start at address zero
// - Request a at one, request b at two
// - Timer events vector to addresses three to seven
// - Serial, UART, comparator vector eight to twelve
// - Pin low over two cycles resets device
// - Enabled watchdog timeout resets device
// - Watchdog reset pulse one cycle, delay follows
// - Reset restores registers, execution from zero
// - After pin release hold core for delay
// - Delay 16 ms, or 1.1 ms fast-start
// - Power-up holds power-on period plus delay
// - Pin held low extends power-on reset
// - Accepting interrupt clears global enable bit
// - Vectoring clears that source's request flag
// - Writing one clears flag; zero no effect
// - Mask register bits 7,6 enables, rest zero
// - Request b sense: rising, falling or level
// - Pin activity requests even as output
// - Request b event sets flag, cleared two ways
`timescale 1ns/1ps
`include "rivu_defs.vh"

module rivu_top #(
  parameter TICK_DIV = `RIVU_CLK_MHZ,
  parameter POR_TICKS = `RIVU_POR_US,
  parameter TOUT_SLOW_TICKS = `RIVU_TOUT_SLOW_US,
  parameter TOUT_FAST_TICKS = `RIVU_TOUT_FAST_US
) (
  input wire core_clk, // 100 MHz clock
  input wire rst, // Power-on reset, sync high
  input wire reset_pin_n, // External reset pin
  input wire fast_start_fuse, // High when fuse programmed
  input wire wdt_enable_in, // Watchdog enabled
  input wire wdt_timeout_in, // Watchdog period elapsed pulse
  input wire ext_request_a_pin, // External request a pin
  input wire ext_request_b_pin, // External request b pin
  input wire [9:0] periph_flag_in, // Peripheral request flags
  input wire [9:0] periph_enable_in, // Peripheral enable bits
  input wire irq_ack_in, // Core loaded vector into PC
  input wire gie_set_in, // Core return sets global enable
  input wire [5:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [7:0] reg_rdata, // Read data, cycle after strobe
  output reg core_reset_out, // Holds core in reset
  output reg irq_req_out, // Interrupt request to core
  output reg [3:0] irq_vector_out, // Vector address
  output reg [9:0] periph_clear_out // Flag clear pulses
);

  localparam ST_POR = 2'h0;
  localparam ST_PIN = 2'h1;
  localparam ST_TOUT = 2'h2;
  localparam ST_RUN = 2'h3;

  // Lowest set bit of pending vector, returns vector address
  function [3:0] rivu_pick;
    input [12:1] pend;
    integer i;
    begin
      rivu_pick = 4'h0;
      for (i = 12; i >= 1; i = i - 1) begin
        if (pend[i]) begin
          rivu_pick = i[3:0];
        end
      end
    end
  endfunction

  // Edge event for one request pin under its sense code
  function rivu_edge;
    input [1:0] sense;
    input lvl;
    input prev;
    begin
      rivu_edge = 1'b0;
      if (sense == `RIVU_SENSE_RISE) begin
        rivu_edge = lvl && !prev;
      end else if (sense == `RIVU_SENSE_FALL) begin
        rivu_edge = !lvl && prev;
      end
    end
  endfunction

  // Register hit for a strobe and an address
  function rivu_hit;
    input strobe;
    input [5:0] addr;
    input [5:0] target;
    begin
      rivu_hit = strobe && (addr == target);
    end
  endfunction

  // Read value of one register, unmapped reads as zero
  function [7:0] rivu_read;
    input [5:0] addr;
    input gie;
    input [1:0] en;
    input [1:0] flag;
    input [3:0] ctrl;
    begin
      case (addr)
        `RIVU_ADDR_STATUS: rivu_read = {gie, 7'h00};
        `RIVU_ADDR_EXT_MASK: rivu_read = {en, 6'h00};
        `RIVU_ADDR_EXT_FLAG: rivu_read = {flag, 6'h00};
        `RIVU_ADDR_CTRL: rivu_read = {4'h0, ctrl};
        default: rivu_read = 8'h00;
      endcase
    end
  endfunction

  // Synchronised pins and their previous levels
  reg [3:0] s1_reg;
  reg [3:0] s2_reg;
  reg [3:0] prev_reg;
  wire pin_n;
  wire fuse;
  wire a_lvl;
  wire b_lvl;

  // Reset sequencer and start-up counters
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [6:0] div_reg;
  reg tick_reg;
  reg [1:0] low_cnt_reg;
  reg wdt_pulse_reg;
  wire pin_rst;
  wire io_rst;
  wire [15:0] tout_ticks;

  // Software registers and request logic
  reg gie_reg;
  reg en_a_reg;
  reg en_b_reg;
  reg flag_a_reg;
  reg flag_b_reg;
  reg [3:0] ctrl_reg;
  wire [1:0] sense_a;
  wire [1:0] sense_b;
  wire ev_a;
  wire ev_b;
  wire req_a;
  wire req_b;
  wire [12:1] pend;
  wire taken;
  wire clr_a;
  wire clr_b;
  wire wr_flag;
  wire wr_status;
  wire wr_mask;
  wire wr_ctrl;

  // Pin synchronisers, first stage read only by second
  always @(posedge core_clk) begin
    if (rst) begin
      s1_reg <= 4'hF;
      s2_reg <= 4'hF;
      prev_reg <= 4'hF;
    end else begin
      s1_reg <= {fast_start_fuse, ext_request_b_pin, ext_request_a_pin, reset_pin_n};
      s2_reg <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  assign pin_n = s2_reg[0];
  assign a_lvl = s2_reg[1];
  assign b_lvl = s2_reg[2];
  assign fuse = s2_reg[3];

  // Microsecond tick divider
  always @(posedge core_clk) begin
    if (rst || div_reg == TICK_DIV - 1) begin
      div_reg <= 7'h00;
      tick_reg <= ~rst;
    end else begin
      div_reg <= div_reg + 7'h01;
      tick_reg <= 1'b0;
    end
  end

  // Pin low length, saturating
  always @(posedge core_clk) begin
    if (rst || pin_n) begin
      low_cnt_reg <= 2'h0;
    end else if (low_cnt_reg != 2'h3) begin
      low_cnt_reg <= low_cnt_reg + 2'h1;
    end
  end

  assign pin_rst = (low_cnt_reg > `RIVU_PIN_LOW_MIN);
  assign tout_ticks = fuse ? TOUT_FAST_TICKS[15:0] : TOUT_SLOW_TICKS[15:0];

  // Reset sequencer next state
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_POR: begin
        if (tick_reg) begin
          cnt_next = cnt_reg + 16'h0001;
        end
        if (cnt_reg >= POR_TICKS[15:0]) begin
          cnt_next = 16'h0000;
          state_next = pin_n ? ST_TOUT : ST_PIN;
        end
      end
      ST_PIN: begin
        cnt_next = 16'h0000;
        if (pin_n) begin
          state_next = ST_TOUT;
        end
      end
      ST_TOUT: begin
        if (tick_reg) begin
          cnt_next = cnt_reg + 16'h0001;
        end
        if (cnt_reg >= tout_ticks) begin
          cnt_next = 16'h0000;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_next = 16'h0000;
        if (wdt_pulse_reg) begin
          state_next = ST_TOUT;
        end
      end
      default: begin
        state_next = ST_POR;
        cnt_next = 16'h0000;
      end
    endcase
    if (pin_rst && state_reg != ST_POR) begin
      state_next = ST_PIN;
      cnt_next = 16'h0000;
    end
  end

  // Reset sequencer registers and watchdog pulse
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_POR;
      cnt_reg <= 16'h0000;
      wdt_pulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wdt_pulse_reg <= (state_reg == ST_RUN) && !wdt_pulse_reg &&
        wdt_enable_in && wdt_timeout_in;
    end
  end

  // Internal reset for software registers and vector outputs
  assign io_rst = rst || state_reg != ST_RUN || wdt_pulse_reg;

  assign sense_a = ctrl_reg[`RIVU_CTRL_SENSE_A_HI:`RIVU_CTRL_SENSE_A_LO];
  assign sense_b = ctrl_reg[`RIVU_CTRL_SENSE_B_HI:`RIVU_CTRL_SENSE_B_LO];

  // Edge events from pin level regardless of pin direction
  assign ev_a = rivu_edge(sense_a, a_lvl, prev_reg[1]);
  assign ev_b = rivu_edge(sense_b, b_lvl, prev_reg[2]);

  // Level mode requests while pin low
  assign req_a = flag_a_reg || (sense_a == `RIVU_SENSE_LEVEL && !a_lvl);
  assign req_b = flag_b_reg || (sense_b == `RIVU_SENSE_LEVEL && !b_lvl);

  // Pending and enabled requests by vector address
  assign pend = {periph_flag_in & periph_enable_in,
    req_b && en_b_reg, req_a && en_a_reg};

  assign taken = irq_ack_in && irq_req_out;
  assign wr_flag = rivu_hit(reg_wr, reg_addr, `RIVU_ADDR_EXT_FLAG);
  assign wr_status = rivu_hit(reg_wr, reg_addr, `RIVU_ADDR_STATUS);
  assign wr_mask = rivu_hit(reg_wr, reg_addr, `RIVU_ADDR_EXT_MASK);
  assign wr_ctrl = rivu_hit(reg_wr, reg_addr, `RIVU_ADDR_CTRL);
  assign clr_a = (taken && irq_vector_out == `RIVU_VEC_EXT_A) ||
    (wr_flag && reg_wdata[`RIVU_BIT_FLAG_A]);
  assign clr_b = (taken && irq_vector_out == `RIVU_VEC_EXT_B) ||
    (wr_flag && reg_wdata[`RIVU_BIT_FLAG_B]);

  // Event flags, hardware set wins over clear
  always @(posedge core_clk) begin
    if (io_rst) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else begin
      flag_a_reg <= (flag_a_reg && !clr_a) || ev_a;
      flag_b_reg <= (flag_b_reg && !clr_b) || ev_b;
    end
  end

  // Global enable: return sets, acceptance clears, software writes
  always @(posedge core_clk) begin
    if (io_rst) begin
      gie_reg <= 1'b0;
    end else if (gie_set_in) begin
      gie_reg <= 1'b1;
    end else if (taken) begin
      gie_reg <= 1'b0;
    end else if (wr_status) begin
      gie_reg <= reg_wdata[`RIVU_BIT_GIE];
    end
  end

  // External request enables in the mask register
  always @(posedge core_clk) begin
    if (io_rst) begin
      en_a_reg <= 1'b0;
      en_b_reg <= 1'b0;
    end else if (wr_mask) begin
      en_b_reg <= reg_wdata[`RIVU_BIT_EN_B];
      en_a_reg <= reg_wdata[`RIVU_BIT_EN_A];
    end
  end

  // Sense control bits for both request pins
  always @(posedge core_clk) begin
    if (io_rst) begin
      ctrl_reg <= `RIVU_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata[3:0];
    end
  end

  // Vector selection toward the core
  always @(posedge core_clk) begin
    if (io_rst) begin
      irq_req_out <= 1'b0;
      irq_vector_out <= `RIVU_VEC_RESET;
      periph_clear_out <= 10'h000;
    end else begin
      irq_req_out <= gie_reg && !taken && !gie_set_in && (|pend);
      if (!irq_req_out || taken) begin
        irq_vector_out <= rivu_pick(pend);
      end
      periph_clear_out <= 10'h000;
      if (taken && irq_vector_out >= `RIVU_VEC_PERIPH0) begin
        periph_clear_out[irq_vector_out - `RIVU_VEC_PERIPH0] <= 1'b1;
      end
    end
  end

  // Core held while sequencer not running
  always @(posedge core_clk) begin
    core_reset_out <= io_rst;
  end

  // Register read port, data in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= `RIVU_RST_REG;
    end else if (reg_rd) begin
      reg_rdata <= rivu_read(reg_addr, gie_reg, {en_b_reg, en_a_reg},
        {flag_b_reg, flag_a_reg}, ctrl_reg);
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// [rivu_asserts.sv]
// Purpose: Port assertions for rivu_top
// Assumes: One clock, rst high
// Notes: Bound below
`timescale 1ns/1ps
module rivu_asserts (
  input wire core_clk, // Clock
  input wire rst, // Reset
  input wire [5:0] reg_addr, // Address
  input wire reg_rd, // Read
  input wire [7:0] reg_rdata, // Read data
  input wire wdt_enable_in, // Dog on
  input wire wdt_timeout_in, // Timeout
  input wire irq_ack_in, // Ack
  input wire [9:0] periph_flag_in, // Flags
  input wire [9:0] periph_enable_in, // Enables
  input wire core_reset_out, // Core hold
  input wire irq_req_out, // Request
  input wire [3:0] irq_vector_out, // Vector
  input wire [9:0] periph_clear_out // Clears
);
  wire [9:0] pe = periph_flag_in & periph_enable_in;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Request taken, request rising
  sequence s_take; irq_req_out && irq_ack_in; endsequence
  sequence s_rise; !irq_req_out ##1 irq_req_out; endsequence
  // Mask read, interrupt handshake and priority, watchdog and reset
  a_mask_read: assert property ($past(reg_rd) && $past(reg_addr) == 6'h3B
    |-> reg_rdata[5:0] == 6'h00) else $error("mask low bits set");
  a_take_drop: assert property (s_take |=> !irq_req_out)
    else $error("request stayed after ack");
  a_vec_hold: assert property (irq_req_out && !irq_ack_in
    |=> irq_req_out && $stable(irq_vector_out)) else $error("request moved");
  a_clear_pulse: assert property (s_take |=> periph_clear_out ==
    ($past(irq_vector_out) >= 4'h3 ? 10'h001 << ($past(irq_vector_out) - 4'h3) : 10'h000))
    else $error("wrong flag clear");
  a_req_enabled: assert property (irq_req_out && irq_vector_out >= 4'h3
    |-> periph_enable_in[irq_vector_out - 4'h3]) else $error("disabled source");
  a_lowest_wins: assert property (s_rise ##0 irq_vector_out >= 4'h3
    |-> ($past(pe) & ((10'h001 << (irq_vector_out - 4'h3)) - 10'h001)) == 10'h000)
    else $error("lower source skipped");
  a_wdt_reset: assert property (wdt_enable_in && wdt_timeout_in && !core_reset_out
    |-> ##[1:4] core_reset_out) else $error("no watchdog reset");
  a_reset_quiet: assert property (core_reset_out
    |-> !irq_req_out && irq_vector_out == 4'h0) else $error("request in reset");
endmodule
bind rivu_top rivu_asserts u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .wdt_enable_in(wdt_enable_in),
  .wdt_timeout_in(wdt_timeout_in),
  .irq_ack_in(irq_ack_in),
  .periph_flag_in(periph_flag_in),
  .periph_enable_in(periph_enable_in),
  .core_reset_out(core_reset_out),
  .irq_req_out(irq_req_out),
  .irq_vector_out(irq_vector_out),
  .periph_clear_out(periph_clear_out)
);

// [rivu_core_model.sv]
// Purpose: Core and peripheral stand-in
// Assumes: Acks after ack_wait cycles
// Notes: Flags set by bench, cleared by block
`timescale 1ns/1ps
module rivu_core_model (
  input wire core_clk, // Clock
  input wire rst, // Reset
  input wire irq_req_out, // Request
  input wire [9:0] periph_clear_out, // Clears
  input wire [9:0] flag_set, // Flag events
  input wire [3:0] ack_wait, // Ack delay
  output reg irq_ack_in, // Vector loaded
  output reg [9:0] periph_flag_in // Flags
);
  reg [3:0] wait_reg;
  // Flags: event sets, clear pulse drops
  always @(posedge core_clk) begin
    if (rst)
      periph_flag_in <= 10'h000;
    else
      periph_flag_in <= (periph_flag_in & ~periph_clear_out) | flag_set;
  end
  // One ack per request, after the wait
  always @(posedge core_clk) begin
    if (rst || !irq_req_out || irq_ack_in) begin
      irq_ack_in <= 1'b0;
      wait_reg <= 4'h0;
    end else if (wait_reg >= ack_wait)
      irq_ack_in <= 1'b1;
    else
      wait_reg <= wait_reg + 4'h1;
  end
endmodule

// [rivu_top_tb.sv]
// Purpose: Self-checking bench for rivu_top
// Assumes: Short tick parameters
// Notes: Core model acks requests
`timescale 1ns/1ps
module rivu_top_tb;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg pin_n = 1'b1;
  reg fuse = 1'b0;
  reg wd_en = 1'b0;
  reg wd_to = 1'b0;
  reg pin_a = 1'b1;
  reg pin_b = 1'b1;
  reg [9:0] en = 10'h3FF;
  reg [9:0] fset = 10'h000;
  reg [5:0] addr = 6'h00;
  reg [7:0] wd = 8'h00;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg gs = 1'b0;
  reg [7:0] d;
  wire [7:0] rdata;
  wire crst, req, ack;
  wire [3:0] vec;
  wire [9:0] pflag, pclr;
  integer bad_count = 0;
  integer cmp_count = 0;
  integer n;
  integer k = 0;
  always #5 core_clk = ~core_clk;
  rivu_top #(.TICK_DIV(2), .POR_TICKS(10), .TOUT_SLOW_TICKS(20), .TOUT_FAST_TICKS(5)) dut (
    .core_clk(core_clk), .rst(rst), .reset_pin_n(pin_n), .fast_start_fuse(fuse),
    .wdt_enable_in(wd_en), .wdt_timeout_in(wd_to), .ext_request_a_pin(pin_a),
    .ext_request_b_pin(pin_b), .periph_flag_in(pflag), .periph_enable_in(en),
    .irq_ack_in(ack), .gie_set_in(gs), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .core_reset_out(crst),
    .irq_req_out(req), .irq_vector_out(vec), .periph_clear_out(pclr));
  rivu_core_model core (.core_clk(core_clk), .rst(rst), .irq_req_out(req),
    .periph_clear_out(pclr), .flag_set(fset), .ack_wait(k[3:0]),
    .irq_ack_in(ack), .periph_flag_in(pflag));
  task test_done;
    begin
      $display("checks %0d bad %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] v);
    begin
      @(posedge core_clk);
      wr_s <= 1'b1;
      addr <= a;
      wd <= v;
      @(posedge core_clk);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [5:0] a);
    begin
      @(posedge core_clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd_s <= 1'b0;
      #1 d = rdata;
    end
  endtask
  // Wait: 0 req high, 3 req low, 1 core run, 2 core held
  task wt(input [1:0] s, output integer c);
    begin
      c = 0;
      while (!((s[0] ^ s[1]) ? crst === s[1] : req === !s[0]) && c < 500) begin
        @(posedge core_clk);
        #1 c = c + 1;
      end
      if (c == 500) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: wait timed out", $time);
        test_done;
      end
    end
  endtask
  // Enable globally, expect vector, await ack
  task irq(input [3:0] v);
    begin
      wr(6'h3F, 8'h80);
      wt(0, n);
      chk({4'h0, vec}, {4'h0, v});
      wt(3, n);
      rd(6'h3F);
      chk(d, 8'h00);
    end
  endtask
  task fl(input [9:0] m);
    begin
      @(posedge core_clk);
      fset <= m;
      @(posedge core_clk);
      fset <= 10'h000;
    end
  endtask
  // Pulse pin b low, and pin a too when m is set
  task pb(input m);
    begin
      @(posedge core_clk);
      pin_b <= 1'b0;
      pin_a <= !m;
      repeat (4) @(posedge core_clk);
      pin_b <= 1'b1;
      pin_a <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wt(1, n);
    chk({7'h0, n >= 58 && n <= 75}, 8'h01);
    rd(6'h3B);
    chk(d, 8'h00);
    wr(6'h3B, 8'hFF);
    rd(6'h3B);
    chk(d, 8'hC0);
    rd(6'h00);
    chk(d, 8'h00);
    $display("done registers");
    for (k = 0; k < 10; k = k + 1) begin
      fl(10'h001 << k);
      irq(k[3:0] + 4'h3);
    end
    fl(10'h204);
    irq(4'h5);
    irq(4'hC);
    en <= 10'h3FE;
    fl(10'h001);
    wr(6'h3F, 8'h80);
    repeat (8) @(posedge core_clk);
    chk({7'h0, req}, 8'h00);
    en <= 10'h3FF;
    wt(0, n);
    chk({4'h0, vec}, 8'h03);
    wt(3, n);
    $display("done vectors");
    pin_a <= 1'b0;
    irq(4'h1);
    pin_a <= 1'b1;
    fuse <= 1'b1;
    wr(6'h3B, 8'h80);
    for (k = 8; k < 16; k = k + 4) begin
      wr(6'h35, k[7:0] | k[5:2]);
      pb(1'b1);
      wr(6'h3A, 8'h00);
      rd(6'h3A);
      chk(d, 8'hC0);
      wr(6'h3A, 8'h80);
      rd(6'h3A);
      chk(d, 8'h40);
      wr(6'h3A, 8'h40);
      rd(6'h3A);
      chk(d, 8'h00);
    end
    pb(1'b0);
    irq(4'h2);
    rd(6'h3A);
    chk(d, 8'h00);
    gs <= 1'b1;
    @(posedge core_clk);
    gs <= 1'b0;
    rd(6'h3F);
    chk(d, 8'h80);
    $display("done external");
    wd_en <= 1'b1;
    wd_to <= 1'b1;
    @(posedge core_clk);
    wd_to <= 1'b0;
    wt(2, n);
    wt(1, n);
    chk({7'h0, n >= 10 && n <= 20}, 8'h01);
    rd(6'h3B);
    chk(d, 8'h00);
    rd(6'h3F);
    chk(d, 8'h00);
    $display("done watchdog");
    pin_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk({7'h0, crst}, 8'h01);
    pin_n <= 1'b1;
    wt(1, n);
    chk({7'h0, n >= 10 && n <= 20}, 8'h01);
    $display("done pin reset");
    pin_n <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (80) @(posedge core_clk);
    chk({7'h0, crst}, 8'h01);
    pin_n <= 1'b1;
    wt(1, n);
    chk({7'h0, n >= 10 && n <= 20}, 8'h01);
    $display("done power-up hold");
    test_done;
  end
endmodule
